// >>> hw/eeprom_write_ctrl.sv
// Purpose: Write-side control of a 256 x 16 serial EEPROM
// Assumes: Array storage outside, driven by the clear/program strobes
// Notes:   WRITE_CYCLES may be shortened for simulation
//
// Overview of operation
// (RL1) Frame: start 1010, opcode, address, data
// (RL2) Bits sampled on rising serial clock
// (RL3) Host selects low; input before start ignored
// (RL4) Write runs auto clear then program
// (RL5) Busy low after last data bit
// (RL6) Busy stays low through whole cycle
// (RL7) Ready held high until next write
// (RL8) Ready/busy pin ignores chip select
// (RL9) Selected during write: output shows status
// (RL10) Deselect returns output to high impedance
// (RL11) After write, output shows ready high
// (RL12) First high input bit floats output
// (RL13) Reset pulse aborts write, reports ready
// (RL14) Reset while shifting discards write, floats
// (RL15) Reset during clear/program shows ready
// (RL16) Reset before busy writes nothing
// (RL17) Host avoids reset while busy
// (RL18) Reset affects only write and write-all
// (RL19) Enable latch clear at power-up
// (RL20) Host enables before writing
// (RL21) Enable latch holds until disable
// (RL22) Latch ignores reads; reset spares enables
// (RL23) Write while disabled is ignored
`timescale 1ns/10ps
module eeprom_write_ctrl
  import eeprom_wr_pkg::*;
#(
  parameter int WRITE_CYCLES = T_WR_CYCLES
)
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              chip_select_n,
  input  wire logic              serial_clock_in,
  input  wire logic              serial_in,
  input  wire logic              write_reset_in,
  output logic                   ready_busy_out,
  output logic                   serial_out,
  output logic                   serial_out_oe,
  output logic                   array_clear_stb,
  output logic                   array_write_stb,
  output logic                   array_write_all,
  output logic [ADDR_W-1:0]      array_addr,
  output logic [DATA_W-1:0]      array_data,
  output logic                   program_enabled
);

  localparam int CLEAR_CYCLES = WRITE_CYCLES / 2;
  localparam int PROG_CYCLES  = WRITE_CYCLES - CLEAR_CYCLES;
  localparam logic [CNT_W-1:0] CLEAR_LOAD = CNT_W'(CLEAR_CYCLES - 1);
  localparam logic [CNT_W-1:0] PROG_LOAD  = CNT_W'(PROG_CYCLES - 1);

  typedef struct packed {
    wr_state_t          st;
    logic [CNT_W-1:0]   cnt;
    logic               enabled;
    logic               rdy;
    logic               hold;
    logic               do_val;
    logic               do_oe;
    logic               clr_stb;
    logic               wr_stb;
    logic               all;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
  } ctl_t;

  ctl_t ctl_reg;
  ctl_t ctl_next;
  logic start_wr;
  logic busy;

  frame_link_if lnk ();

  frame_rx u_frame_rx (
    .clk_sys         (clk_sys),
    .srst            (srst),
    .chip_select_n   (chip_select_n),
    .serial_clock_in (serial_clock_in),
    .serial_in       (serial_in),
    .write_reset_in  (write_reset_in),
    .lnk             (lnk)
  );

  assign busy = (ctl_reg.st != WR_IDLE);

  // Accepted write: enabled, idle, not discarded, no reset level
  assign start_wr = lnk.cmd_valid && is_write_op(lnk.opcode)
                    && ctl_reg.enabled // RL23
                    && !lnk.kill // RL14
                    && !lnk.abort // RL16
                    && !busy;

  always_comb
  begin
    ctl_next         = ctl_reg;
    ctl_next.clr_stb = 1'b0;
    ctl_next.wr_stb  = 1'b0;

    if (lnk.cmd_valid)
    begin
      unique case (lnk.opcode)
        OP_ENABLE:
        begin
          ctl_next.enabled = 1'b1; // RL22
        end
        OP_DISABLE:
        begin
          ctl_next.enabled = 1'b0; // RL21 RL22
        end
        default:
        begin
        end
      endcase
    end

    // First high input bit after ready releases the status drive
    if (lnk.one_rise && !busy)
    begin
      ctl_next.hold = 1'b0; // RL12
    end

    if (start_wr)
    begin
      ctl_next.st   = WR_CLEAR; // RL4
      ctl_next.cnt  = CLEAR_LOAD;
      ctl_next.rdy  = 1'b0; // RL5
      ctl_next.hold = 1'b0;
      ctl_next.all  = (lnk.opcode == OP_WRITE_ALL);
      ctl_next.addr = lnk.addr;
      ctl_next.data = lnk.data;
    end

    unique case (ctl_reg.st)
      WR_IDLE:
      begin
      end
      WR_CLEAR:
      begin
        if (ctl_reg.cnt == '0)
        begin
          ctl_next.clr_stb = 1'b1; // RL4
          ctl_next.st      = WR_PROGRAM;
          ctl_next.cnt     = PROG_LOAD;
        end
        else
        begin
          ctl_next.cnt = ctl_reg.cnt - CNT_W'(1); // RL6
        end
      end
      WR_PROGRAM:
      begin
        if (ctl_reg.cnt == '0)
        begin
          ctl_next.wr_stb = 1'b1; // RL4
          ctl_next.st     = WR_IDLE;
          ctl_next.rdy    = 1'b1; // RL6 RL7
          ctl_next.hold   = 1'b1; // RL11
        end
        else
        begin
          ctl_next.cnt = ctl_reg.cnt - CNT_W'(1); // RL6
        end
      end
      default:
      begin
        ctl_next.st = WR_IDLE;
      end
    endcase

    // Reset pin stops only a running clear or program cycle
    if (lnk.abort && busy)
    begin
      ctl_next.st      = WR_IDLE; // RL13 RL15 RL18
      ctl_next.wr_stb  = 1'b0;
      ctl_next.clr_stb = 1'b0;
      ctl_next.rdy     = 1'b1; // RL13
      ctl_next.hold    = 1'b1; // RL15
    end

    // Status pin is driven only while selected
    ctl_next.do_oe  = !lnk.cs_n // RL9 RL10
                      && (ctl_next.st != WR_IDLE || ctl_next.hold);
    ctl_next.do_val = ctl_next.rdy; // RL8 RL9
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctl_reg         <= '0;
      ctl_reg.st      <= WR_IDLE;
      ctl_reg.rdy     <= 1'b1;
      ctl_reg.do_val  <= 1'b1;
      ctl_reg.enabled <= 1'b0; // RL19
    end
    else
    begin
      ctl_reg <= ctl_next;
    end
  end

  assign ready_busy_out  = ctl_reg.rdy;
  assign serial_out      = ctl_reg.do_val;
  assign serial_out_oe   = ctl_reg.do_oe;
  assign array_clear_stb = ctl_reg.clr_stb;
  assign array_write_stb = ctl_reg.wr_stb;
  assign array_write_all = ctl_reg.all;
  assign array_addr      = ctl_reg.addr;
  assign array_data      = ctl_reg.data;
  assign program_enabled = ctl_reg.enabled;

  AST_BUSY_AFTER_WRITE: assert property ( // RL5
    @(posedge clk_sys) disable iff (srst)
    start_wr |=> !ready_busy_out && ctl_reg.st == WR_CLEAR
  ) else $error("Busy not shown after write frame");

  AST_READY_RISE_CAUSE: assert property ( // RL6
    @(posedge clk_sys) disable iff (srst)
    $rose(ready_busy_out) |-> array_write_stb || $past(lnk.abort)
  ) else $error("Ready returned before cycle end");

  AST_READY_STAYS: assert property ( // RL7
    @(posedge clk_sys) disable iff (srst)
    ready_busy_out && !start_wr |=> ready_busy_out
  ) else $error("Ready dropped without a write");

  AST_RDY_IGNORES_CS: assert property ( // RL8
    @(posedge clk_sys) disable iff (srst)
    $changed(lnk.cs_n) && !start_wr && !lnk.abort && ctl_reg.cnt != '0
      |=> $stable(ready_busy_out)
  ) else $error("Ready/busy moved with chip select");

  AST_DO_SHOWS_BUSY: assert property ( // RL9
    @(posedge clk_sys) disable iff (srst)
    !lnk.cs_n && busy && !lnk.abort && ctl_reg.cnt != '0
      |=> serial_out_oe && !serial_out
  ) else $error("Serial output not showing busy");

  AST_DO_HIZ_DESELECT: assert property ( // RL10
    @(posedge clk_sys) disable iff (srst)
    lnk.cs_n |=> !serial_out_oe
  ) else $error("Serial output driven while deselected");

  AST_DO_READY_AFTER: assert property ( // RL11
    @(posedge clk_sys) disable iff (srst)
    array_write_stb && !lnk.cs_n && !lnk.one_rise
      |=> serial_out_oe && serial_out
  ) else $error("Ready not shown on serial output");

  AST_DO_RELEASE_ONE: assert property ( // RL12
    @(posedge clk_sys) disable iff (srst)
    lnk.one_rise && !busy && !start_wr |=> !serial_out_oe
  ) else $error("High input bit did not float output");

  AST_ABORT_READY: assert property ( // RL15
    @(posedge clk_sys) disable iff (srst)
    lnk.abort && busy
      |=> ready_busy_out && !array_write_stb && ctl_reg.st == WR_IDLE
  ) else $error("Reset did not abort write cycle");

  AST_KILL_DISCARD: assert property ( // RL14
    @(posedge clk_sys) disable iff (srst)
    lnk.cmd_valid && lnk.kill && is_write_op(lnk.opcode) && !busy
      |=> ctl_reg.st == WR_IDLE ##1 ctl_reg.st == WR_IDLE
  ) else $error("Discarded write started a cycle");

  AST_CLEAR_BEFORE_PROG: assert property ( // RL4
    @(posedge clk_sys) disable iff (srst)
    array_write_stb |-> $past(ctl_reg.st) == WR_PROGRAM
  ) else $error("Program strobe outside program cycle");

  AST_LATCH_POWERUP: assert property ( // RL19
    @(posedge clk_sys)
    srst |=> !program_enabled
  ) else $error("Enable latch set after power-up");

  AST_LATCH_STICKY: assert property ( // RL21
    @(posedge clk_sys) disable iff (srst)
    program_enabled && !(lnk.cmd_valid && lnk.opcode == OP_DISABLE)
      |=> program_enabled
  ) else $error("Enable latch lost without disable");

  AST_DISABLED_IGNORED: assert property ( // RL23
    @(posedge clk_sys) disable iff (srst)
    lnk.cmd_valid && is_write_op(lnk.opcode) && !program_enabled
      && ready_busy_out |=> ready_busy_out [*2]
  ) else $error("Write accepted while disabled");

  AST_ENABLE_UNDER_RESET: assert property ( // RL22
    @(posedge clk_sys) disable iff (srst)
    lnk.cmd_valid && lnk.opcode == OP_ENABLE && lnk.abort
      |=> program_enabled
  ) else $error("Enable disturbed by reset pin");

endmodule : eeprom_write_ctrl

// >>> hw/eeprom_wr_pkg.sv
// Purpose: Shared constants and types of the EEPROM write control
// Assumes: 200 MHz system clock
// Notes:   Opcodes are the 4 bits that follow the start pattern
package eeprom_wr_pkg;

  localparam logic [3:0] START_PATTERN = 4'hA;
  localparam logic [3:0] OP_READ       = 4'h8;
  localparam logic [3:0] OP_WRITE      = 4'h4;
  localparam logic [3:0] OP_ENABLE     = 4'h3;
  localparam logic [3:0] OP_DISABLE    = 4'h0;
  localparam logic [3:0] OP_WRITE_ALL  = 4'h1;

  localparam logic [3:0] HDR_LAST  = 4'hB;
  localparam logic [3:0] DATA_LAST = 4'hF;
  localparam int         ADDR_W    = 8;
  localparam int         DATA_W    = 16;

  localparam int CLK_FREQ_MHZ = 200;
  localparam int T_WR_MS      = 5;
  localparam int T_WR_CYCLES  = T_WR_MS * 1000 * CLK_FREQ_MHZ;
  localparam int CNT_W        = 20;

  typedef enum logic [1:0] {
    RX_HUNT   = 2'b00,
    RX_HEADER = 2'b01,
    RX_DATA   = 2'b10,
    RX_DONE   = 2'b11
  } rx_state_t;

  typedef enum logic [1:0] {
    WR_IDLE    = 2'b00,
    WR_CLEAR   = 2'b01,
    WR_PROGRAM = 2'b10
  } wr_state_t;

  function automatic logic is_write_op(input logic [3:0] op);
    return (op == OP_WRITE) || (op == OP_WRITE_ALL);
  endfunction : is_write_op

endpackage : eeprom_wr_pkg

// >>> hw/frame_link_if.sv
// Purpose: Carries decoded frames from the receiver to the control
// Assumes: All signals registered on clk_sys by the receiver
// Notes:   cs_n and abort are the synchronised pin levels
`timescale 1ns/10ps
interface frame_link_if;
  logic        cmd_valid;
  logic [3:0]  opcode;
  logic [7:0]  addr;
  logic [15:0] data;
  logic        kill;
  logic        one_rise;
  logic        cs_n;
  logic        abort;

  modport rx (
    output cmd_valid, opcode, addr, data, kill, one_rise, cs_n, abort
  );
  modport ctrl (
    input  cmd_valid, opcode, addr, data, kill, one_rise, cs_n, abort
  );
endinterface : frame_link_if

// >>> hw/frame_rx.sv
// Purpose: Synchronises the serial pins and decodes instruction frames
// Assumes: Serial clock far slower than clk_sys
// Notes:   Bits after a complete frame are not decoded until deselect; high bits still set one_rise
`timescale 1ns/10ps
module frame_rx
  import eeprom_wr_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic chip_select_n,
  input  wire logic serial_clock_in,
  input  wire logic serial_in,
  input  wire logic write_reset_in,
  frame_link_if.rx  lnk
);

  typedef struct packed {
    logic [1:0]  cs_s;
    logic [1:0]  sk_s;
    logic        sk_prev;
    logic [1:0]  di_s;
    logic [1:0]  rst_s;
    rx_state_t   st;
    logic [3:0]  hunt;
    logic [11:0] hdr;
    logic [15:0] data;
    logic [3:0]  cnt;
    logic        valid;
    logic        one;
    logic        kill;
  } rx_t;

  rx_t rx_reg;
  rx_t rx_next;
  logic rise;
  logic bit_in;
  logic sel_n;

  assign rise   = rx_reg.sk_s[1] & ~rx_reg.sk_prev;
  assign bit_in = rx_reg.di_s[1];
  assign sel_n  = rx_reg.cs_s[1];

  always_comb
  begin
    rx_next         = rx_reg;
    rx_next.cs_s    = {rx_reg.cs_s[0], chip_select_n};
    rx_next.sk_s    = {rx_reg.sk_s[0], serial_clock_in};
    rx_next.di_s    = {rx_reg.di_s[0], serial_in};
    rx_next.rst_s   = {rx_reg.rst_s[0], write_reset_in};
    rx_next.sk_prev = rx_reg.sk_s[1];
    rx_next.valid   = 1'b0;
    rx_next.one     = rise & bit_in & ~sel_n;
    if (sel_n)
    begin
      // Deselect rearms the start-pattern hunt
      rx_next.st   = RX_HUNT; // RL3
      rx_next.hunt = '0;
      rx_next.cnt  = '0;
      rx_next.kill = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        unique case (rx_reg.st)
          RX_HUNT:
          begin
            rx_next.hunt = {rx_reg.hunt[2:0], bit_in}; // RL2
            if (rx_next.hunt == START_PATTERN) // RL1 RL3
            begin
              rx_next.st = RX_HEADER;
            end
          end
          RX_HEADER:
          begin
            rx_next.hdr = {rx_reg.hdr[10:0], bit_in}; // RL1
            rx_next.cnt = rx_reg.cnt + 4'h1;
            if (rx_reg.cnt == HDR_LAST)
            begin
              rx_next.cnt = '0;
              if (is_write_op(rx_next.hdr[11:8]))
              begin
                rx_next.st = RX_DATA;
              end
              else
              begin
                rx_next.valid = 1'b1;
                rx_next.st    = RX_DONE;
              end
            end
          end
          RX_DATA:
          begin
            rx_next.data = {rx_reg.data[14:0], bit_in}; // RL1
            rx_next.cnt  = rx_reg.cnt + 4'h1;
            if (rx_reg.cnt == DATA_LAST)
            begin
              rx_next.valid = 1'b1;
              rx_next.st    = RX_DONE;
            end
          end
          RX_DONE:
          begin
          end
        endcase
      end
      // Reset while a frame shifts marks it for discard
      if ((rx_reg.st == RX_HEADER || rx_reg.st == RX_DATA)
          && rx_reg.rst_s[1])
      begin
        rx_next.kill = 1'b1; // RL14
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rx_reg <= '0;
    else
      rx_reg <= rx_next;
  end

  assign lnk.cmd_valid = rx_reg.valid;
  assign lnk.opcode    = rx_reg.hdr[11:8];
  assign lnk.addr      = rx_reg.hdr[7:0];
  assign lnk.data      = rx_reg.data;
  assign lnk.kill      = rx_reg.kill;
  assign lnk.one_rise  = rx_reg.one;
  assign lnk.cs_n      = rx_reg.cs_s[1];
  assign lnk.abort     = rx_reg.rst_s[1];

endmodule : frame_rx

// >>> verif/serial_host_model.sv
// Purpose: Host controller model on the serial pins of the EEPROM
// Assumes: Pins change 1 ns after a clk_sys rise, 4-cycle SK phases
// Notes:   SK stands low outside frames; DI inverts when released
`timescale 1ns/10ps
module serial_host_model
(
  input  wire logic clk_sys,
  output logic      chip_select_n,
  output logic      serial_clock_in,
  output logic      serial_in
);
  initial
  begin
    chip_select_n   = 1'b1;
    serial_clock_in = 1'b0;
    serial_in       = 1'b0;
  end

  // High-to-low select before each start pattern
  task automatic select_dev;
    @(posedge clk_sys);
    #1 chip_select_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : select_dev

  task automatic deselect_dev;
    @(posedge clk_sys);
    #1 chip_select_n = 1'b1;
    serial_in = ~serial_in;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : deselect_dev

  // MSB first, data settled before each rising SK edge
  task automatic shift(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clk_sys);
      #1 serial_clock_in = 1'b0;
      serial_in = v[i];
      repeat (4) @(posedge clk_sys);
      #1 serial_clock_in = 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    #1 serial_clock_in = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : shift
endmodule : serial_host_model

// >>> verif/serial_eeprom_write_control_bench.sv
// Purpose: Self-checking bench of the EEPROM write control
// Assumes: WRITE_CYCLES shortened to 40
// Notes:   Strobes and busy length are gathered by a monitor
`timescale 1ns/10ps
module serial_eeprom_write_control_bench;
  import eeprom_wr_pkg::*;
  localparam int WR_CYC = 40;
  logic              clk_sys = 1'b0;
  logic              srst;
  logic              write_reset_in;
  wire               cs_n, sck, sdi, rb, so, so_oe, clr_stb, wr_stb, wr_all;
  wire [ADDR_W-1:0]  a_addr;
  wire [DATA_W-1:0]  a_data;
  wire               en;
  int                error_cnt = 0;
  int                n_tests   = 0;
  int                cyc, t_clr, t_wr, n_clr, n_wr, run, busy_len;
  logic [31:0]       wr_addr, wr_data;

  always #2.5 clk_sys = ~clk_sys;

  serial_host_model i_host (.clk_sys(clk_sys), .chip_select_n(cs_n),
    .serial_clock_in(sck), .serial_in(sdi));

  eeprom_write_ctrl #(.WRITE_CYCLES(WR_CYC)) i_dut (.clk_sys(clk_sys),
    .srst(srst), .chip_select_n(cs_n), .serial_clock_in(sck),
    .serial_in(sdi), .write_reset_in(write_reset_in),
    .ready_busy_out(rb), .serial_out(so), .serial_out_oe(so_oe),
    .array_clear_stb(clr_stb), .array_write_stb(wr_stb),
    .array_write_all(wr_all), .array_addr(a_addr), .array_data(a_data),
    .program_enabled(en));

  always @(posedge clk_sys)
  begin
    cyc++;
    if (rb === 1'b0)
      run++;
    else if (run != 0)
    begin
      busy_len = run;
      run = 0;
    end
    if (clr_stb === 1'b1)
    begin
      n_clr++;
      t_clr = cyc;
    end
    if (wr_stb === 1'b1)
    begin
      n_wr++;
      t_wr = cyc;
      wr_addr = {24'h000000, a_addr};
      wr_data = {16'h0000, a_data};
    end
  end

  task automatic check_bit(input string name, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b got %b", name, e, g);
    end
  endtask : check_bit

  task automatic check_val(input string name, input logic [31:0] e,
                           input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", name, e, g);
    end
  endtask : check_val

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cyc

  task automatic wait_rb(input logic lvl, input int lim);
    int k;
    k = 0;
    while (rb !== lvl && k < lim)
    begin
      wait_cyc(1);
      k++;
    end
    check_bit("ready_busy_out", lvl, rb);
  endtask : wait_rb

  task automatic frame(input logic [31:0] v, input int n);
    i_host.select_dev();
    i_host.shift(v, n);
    i_host.deselect_dev();
  endtask : frame

  task automatic t_gate;
    check_bit("program_enabled", 1'b0, en);
    frame({START_PATTERN, OP_WRITE, 8'h11, 16'h1234}, 32);
    wait_cyc(50);
    check_bit("ready_busy_out", 1'b1, rb);
    check_val("clear count", 0, n_clr);
    frame({16'h0000, START_PATTERN, OP_ENABLE, 8'h00}, 19);
    check_bit("program_enabled", 1'b1, en);
    frame({START_PATTERN, OP_READ, 8'h11, 16'h0000}, 32);
    wait_cyc(30);
    check_bit("ready_busy_out", 1'b1, rb);
    $display("test gate done");
  endtask : t_gate

  task automatic t_write(input logic [3:0] op, input logic [7:0] ad,
                         input logic [15:0] d);
    int c0, w0;
    c0 = n_clr;
    w0 = n_wr;
    i_host.select_dev();
    i_host.shift({START_PATTERN, op, ad, d}, 32);
    wait_rb(1'b0, 20);
    check_bit("serial_out_oe", 1'b1, so_oe);
    check_bit("serial_out", 1'b0, so);
    i_host.deselect_dev();
    check_bit("serial_out_oe", 1'b0, so_oe);
    check_bit("ready_busy_out", 1'b0, rb);
    i_host.select_dev();
    check_bit("serial_out_oe", 1'b1, so_oe);
    wait_rb(1'b1, 60);
    wait_cyc(2);
    check_val("busy length", WR_CYC, busy_len);
    check_bit("serial_out_oe", 1'b1, so_oe);
    check_bit("serial_out", 1'b1, so);
    check_val("clear count", c0 + 1, n_clr);
    check_val("write count", w0 + 1, n_wr);
    check_val("clear to program", WR_CYC - WR_CYC / 2, t_wr - t_clr);
    check_val("address", {24'h000000, ad}, wr_addr);
    check_val("data", {16'h0000, d}, wr_data);
    check_bit("array_write_all", op == OP_WRITE_ALL, wr_all);
    check_bit("program_enabled", 1'b1, en);
    wait_cyc(20);
    check_bit("ready_busy_out", 1'b1, rb);
    i_host.shift(32'h00000001, 1);
    check_bit("serial_out_oe", 1'b0, so_oe);
    i_host.deselect_dev();
    $display("test write %h done", op);
  endtask : t_write

  task automatic t_reset_busy;
    int w0;
    w0 = n_wr;
    i_host.select_dev();
    i_host.shift({START_PATTERN, OP_WRITE, 8'h22, 16'hBEEF}, 32);
    wait_rb(1'b0, 20);
    wait_cyc(5);
    write_reset_in = 1'b1;
    wait_rb(1'b1, 10);
    wait_cyc(2);
    check_bit("serial_out_oe", 1'b1, so_oe);
    check_bit("serial_out", 1'b1, so);
    write_reset_in = 1'b0;
    wait_cyc(WR_CYC);
    check_val("write count", w0, n_wr);
    i_host.deselect_dev();
    $display("test reset busy done");
  endtask : t_reset_busy

  task automatic t_reset_shift;
    int c0;
    c0 = n_clr;
    i_host.select_dev();
    i_host.shift({16'h0000, START_PATTERN, OP_WRITE, 8'h33}, 16);
    write_reset_in = 1'b1;
    i_host.shift(32'h0000005A, 8);
    // Reset gone again before the last bit: the discard must still hold
    write_reset_in = 1'b0;
    i_host.shift(32'h0000005A, 8);
    wait_cyc(20);
    check_bit("ready_busy_out", 1'b1, rb);
    check_bit("serial_out_oe", 1'b0, so_oe);
    check_val("clear count", c0, n_clr);
    write_reset_in = 1'b0;
    i_host.deselect_dev();
    $display("test reset shift done");
  endtask : t_reset_shift

  task automatic t_latch;
    write_reset_in = 1'b1;
    frame({16'h0000, START_PATTERN, OP_DISABLE, 8'h00}, 16);
    check_bit("program_enabled", 1'b0, en);
    frame({16'h0000, START_PATTERN, OP_ENABLE, 8'h00}, 16);
    check_bit("program_enabled", 1'b1, en);
    write_reset_in = 1'b0;
    frame({16'h0000, START_PATTERN, OP_DISABLE, 8'h00}, 16);
    frame({START_PATTERN, OP_WRITE, 8'h44, 16'h0F0F}, 32);
    wait_cyc(20);
    check_bit("ready_busy_out", 1'b1, rb);
    $display("test latch done");
  endtask : t_latch

  // Mid-run power-up reset must clear the enable latch again
  task automatic t_power;
    frame({16'h0000, START_PATTERN, OP_ENABLE, 8'h00}, 16);
    check_bit("program_enabled", 1'b1, en);
    srst = 1'b1;
    wait_cyc(3);
    srst = 1'b0;
    wait_cyc(3);
    check_bit("program_enabled", 1'b0, en);
    check_bit("ready_busy_out", 1'b1, rb);
    check_bit("serial_out_oe", 1'b0, so_oe);
    $display("test power-up done");
  endtask : t_power

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end

  initial
  begin
    srst = 1'b1;
    write_reset_in = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 srst = 1'b0;
    wait_cyc(3);
    t_gate();
    t_write(OP_WRITE, 8'hA5, 16'hC3F0);
    t_write(OP_WRITE_ALL, 8'hFF, 16'h8001);
    t_reset_busy();
    t_reset_shift();
    t_latch();
    t_power();
    stop_test();
  end
endmodule : serial_eeprom_write_control_bench
